// [pkg/nas_pkg.sv]
package nas_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned DETACH_PERIOD_MS = 3000;
    localparam int unsigned IDLE_PERIOD_MS   = 1000;
    localparam int unsigned TX_LAMP_MS       = 100;
    localparam int unsigned FLASH_ON_MS      = 50;
    localparam int unsigned IDENT_HALF_MS    = 100;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DETACHED = 8'h00;
    localparam logic [7:0] ADDR_MAX      = 8'hfa;
    localparam logic [3:0] NIBBLE_RESET  = 4'h0;

    // ----------------------------------------------------------------
    // Routing and processing defaults
    // ----------------------------------------------------------------
    localparam logic [1:0] ROUTE_2IN_2OUT = 2'h0;
    localparam logic [1:0] ROUTE_RESET    = 2'h0;

    // Lamp display modes
    typedef enum logic [2:0]
    {
        NAS_LAMP_DETACHED = 3'b000,
        NAS_LAMP_IDLE     = 3'b001,
        NAS_LAMP_ACTIVE   = 3'b010,
        NAS_LAMP_IDENT    = 3'b011,
        NAS_LAMP_INVALID  = 3'b100
    } nas_lamp_e;

    // Configuration handed to the signal path
    typedef struct packed
    {
        logic       bypass;
        logic       dsp_enable;
        logic [1:0] routing;
        logic       params_clear;
    } nas_cfg_s;

    // Network participation status
    typedef struct packed
    {
        logic [7:0] node_addr;
        logic       addr_valid;
        logic       net_enable;
        logic       bus_seen;
    } nas_net_s;

endpackage

// [verilog/nas_ms_tick.sv]
`timescale 1ns/1ps

// One-cycle enable pulse every millisecond
module nas_ms_tick
    import nas_pkg::*;
#(
    parameter int unsigned DIV = CYC_PER_MS
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Tick out
    output logic      tick
);

    localparam int unsigned CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    // --------------------------------------------------------------
    // Divider
    // --------------------------------------------------------------
    always_comb
    begin
        next_tick = 1'b0;
        next_cnt  = cnt + 1'b1;
        if (cnt == CW'(DIV - 1))
        begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    // Divider registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule

// [verilog/nas_status.sv]
`timescale 1ns/1ps

// What this block does
// RULE1: node address is high selector as upper nibble, low selector as lower.
// RULE2: addresses one to 250 are valid network node addresses.
// RULE3: address zero keeps the unit off the network entirely.
// RULE4: address zero at power-up zeroes parameters, routes 2-in-2, disables processing.
// RULE5: address zero flashes the lamp once per three seconds.
// RULE6: valid address without bus activity flashes the lamp once per second.
// RULE7: after bus seen, each own transmission lights lamp at least 100 ms.
// RULE8: identify command from host flashes lamp fast; others stay dark.
// RULE9: every node on one network must have a unique address.
// RULE10: selectors latched once after reset; transmit pulse retriggers.
module nas_status
    import nas_pkg::*;
#(
    parameter int unsigned MS_DIV = CYC_PER_MS
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Rotary selectors (pins)
    input  wire logic [3:0] sel_high,
    input  wire logic [3:0] sel_low,
    // Bus controller events (same clock)
    input  wire logic       bus_activity,
    input  wire logic       own_tx,
    input  wire logic       ident_on,
    input  wire logic       ident_off,
    // Results
    output nas_net_s        net,
    output nas_cfg_s        cfg,
    output logic            lamp
);

    // --------------------------------------------------------------
    // Selector synchronisers
    // --------------------------------------------------------------
    logic [7:0] sel_s1, sel_s2, sel_s3;
    logic [1:0] boot_cnt;
    logic [1:0] next_boot_cnt;
    logic       latched;
    logic       next_latched;
    logic [7:0] addr;
    logic [7:0] next_addr;

    // Three-stage capture of both selectors
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_s1 <= 8'h00;
            sel_s2 <= 8'h00;
            sel_s3 <= 8'h00;
        end
        else
        begin
            sel_s1 <= {sel_high, sel_low}; // RULE1
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
        end
    end

    // Latch once after reset when stages two and three agree
    always_comb
    begin
        next_boot_cnt = boot_cnt;
        next_latched  = latched;
        next_addr     = addr;
        if (!latched)
        begin
            if (boot_cnt != 2'h3)
            begin
                next_boot_cnt = boot_cnt + 2'h1;
            end
            else if (sel_s2 == sel_s3)
            begin
                next_addr    = sel_s3; // RULE10
                next_latched = 1'b1;
            end
        end
    end

    // Address registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            boot_cnt <= 2'h0;
            latched  <= 1'b0;
            addr     <= ADDR_DETACHED;
        end
        else
        begin
            boot_cnt <= next_boot_cnt;
            latched  <= next_latched;
            addr     <= next_addr;
        end
    end

    // --------------------------------------------------------------
    // Network state
    // --------------------------------------------------------------
    logic addr_ok;
    logic detached;
    logic bus_seen;
    logic next_bus_seen;
    logic ident;
    logic next_ident;

    assign addr_ok  = latched && addr != ADDR_DETACHED && addr <= ADDR_MAX; // RULE2
    assign detached = latched && addr == ADDR_DETACHED;

    // Bus-seen and identify flags; set wins over clear
    always_comb
    begin
        next_bus_seen = bus_seen | (addr_ok & bus_activity);
        next_ident    = ident;
        if (ident_off)
        begin
            next_ident = 1'b0;
        end
        if (ident_on && addr_ok)
        begin
            next_ident = 1'b1; // RULE8
        end
    end

    // Network registers and outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bus_seen <= 1'b0;
            ident    <= 1'b0;
            net      <= '0;
            cfg      <= '{bypass: 1'b1, dsp_enable: 1'b0, routing: ROUTE_RESET, params_clear: 1'b1};
        end
        else
        begin
            bus_seen        <= next_bus_seen;
            ident           <= next_ident;
            net.node_addr   <= addr;
            net.addr_valid  <= addr_ok;
            net.net_enable  <= addr_ok; // RULE3
            net.bus_seen    <= bus_seen;
            cfg.bypass      <= !latched || detached; // RULE4
            cfg.dsp_enable  <= latched && !detached;
            cfg.routing     <= ROUTE_2IN_2OUT;
            cfg.params_clear <= !latched || detached;
        end
    end

    // --------------------------------------------------------------
    // Lamp timing
    // --------------------------------------------------------------
    logic        ms_tick;
    logic [11:0] per_cnt;
    logic [11:0] next_per_cnt;
    logic [6:0]  tx_cnt;
    logic [6:0]  next_tx_cnt;
    logic        tx_hit;
    logic        next_tx_hit;
    nas_lamp_e   mode;
    logic        next_lamp;

    nas_ms_tick #(.DIV(MS_DIV)) u_tick
    (
        .clk  (clk),
        .rst  (rst),
        .tick (ms_tick)
    );

    // Select lamp mode; identify beats all
    always_comb
    begin
        if (ident)
            mode = NAS_LAMP_IDENT;
        else if (detached)
            mode = NAS_LAMP_DETACHED;
        else if (addr_ok && !bus_seen)
            mode = NAS_LAMP_IDLE;
        else if (addr_ok)
            mode = NAS_LAMP_ACTIVE;
        else
            mode = NAS_LAMP_INVALID;
    end

    // Period counter, transmit stretch and lamp value
    always_comb
    begin
        next_per_cnt = per_cnt;
        next_tx_cnt  = tx_cnt;
        next_tx_hit  = 1'b0;
        if (ms_tick)
        begin
            next_per_cnt = (per_cnt >= 12'(DETACH_PERIOD_MS - 1)) ? 12'h000 : per_cnt + 12'h001;
            if (tx_cnt != 7'h00)
                next_tx_cnt = tx_cnt - 7'h01;
        end
        // One spare tick: the first tick may land right after the load
        if (own_tx && bus_seen && addr_ok)
        begin
            next_tx_cnt = 7'(TX_LAMP_MS + 1); // RULE7 RULE10
            next_tx_hit = 1'b1;
        end
        unique case (mode)
            NAS_LAMP_DETACHED: next_lamp = per_cnt < 12'(FLASH_ON_MS); // RULE5
            NAS_LAMP_IDLE:     next_lamp = (per_cnt % 12'(IDLE_PERIOD_MS)) < 12'(FLASH_ON_MS); // RULE6
            NAS_LAMP_ACTIVE:   next_lamp = tx_cnt != 7'h00 || tx_hit; // RULE7
            NAS_LAMP_IDENT:    next_lamp = ((per_cnt / 12'(IDENT_HALF_MS)) & 12'h001) == 12'h000; // RULE8
            default:           next_lamp = 1'b0;
        endcase
    end

    // Lamp registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            per_cnt <= 12'h000;
            tx_cnt  <= 7'h00;
            tx_hit  <= 1'b0;
            lamp    <= 1'b0;
        end
        else
        begin
            per_cnt <= next_per_cnt;
            tx_cnt  <= next_tx_cnt;
            tx_hit  <= next_tx_hit;
            lamp    <= next_lamp;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_detach_offnet: assert property (@(posedge clk) disable iff (rst) // RULE3
        detached |=> !net.net_enable) else $error("detached unit on network");
    chk_detach_bypass: assert property (@(posedge clk) disable iff (rst) // RULE4
        detached |=> cfg.bypass && !cfg.dsp_enable && cfg.routing == ROUTE_2IN_2OUT)
        else $error("detached config wrong");
    chk_range_valid: assert property (@(posedge clk) disable iff (rst) // RULE2
        net.addr_valid |-> net.node_addr != ADDR_DETACHED && net.node_addr <= ADDR_MAX)
        else $error("bad valid address");
    chk_tx_lamp: assert property (@(posedge clk) disable iff (rst) // RULE7
        (own_tx && bus_seen && addr_ok && !ident) ##1 (mode == NAS_LAMP_ACTIVE) |=> lamp)
        else $error("transmit lamp missing");
    chk_tx_hold: assert property (@(posedge clk) disable iff (rst) // RULE7
        (mode == NAS_LAMP_ACTIVE && tx_cnt > 7'h01) |=> lamp || mode != NAS_LAMP_ACTIVE)
        else $error("transmit lamp short");
    chk_ident_dark: assert property (@(posedge clk) disable iff (rst) // RULE8
        (ident_on && !addr_ok) |=> !ident) else $error("identify on unaddressed node");
    chk_addr_stable: assert property (@(posedge clk) disable iff (rst) // RULE10
        latched |=> latched && $stable(addr)) else $error("address changed after latch");
    chk_detach_flash: assert property (@(posedge clk) disable iff (rst) // RULE5
        (mode == NAS_LAMP_DETACHED && per_cnt >= 12'(FLASH_ON_MS)) |=> !lamp || mode != NAS_LAMP_DETACHED)
        else $error("detached lamp on too long");
    chk_nibble_order: assert property (@(posedge clk) disable iff (rst) // RULE1
        1'b1 |=> sel_s1 == {$past(sel_high), $past(sel_low)}) else $error("nibble order");

endmodule

// [dv/nas_bus_node.sv]
`timescale 1ns/1ps

// Far-side bus node: host PC and peer amplifiers
module nas_bus_node
(
    // Clock
    input  wire logic       clk,
    // Address the host knows the unit by
    input  wire logic [7:0] dut_addr,
    // Bus events towards the unit
    output logic            bus_activity,
    output logic            ident_on,
    output logic            ident_off
);
    // Own address kept outside the node range so it never clashes
    localparam logic [7:0] OWN_ADDR = 8'hfe;

    initial {bus_activity, ident_on, ident_off} = 3'h0;

    // One frame seen on the bus, one cycle wide
    task automatic frame();
        @(negedge clk) bus_activity = 1'b1;
        @(negedge clk) bus_activity = 1'b0;
    endtask

    // Identify request reaches only the addressed node
    task automatic ident(input logic [7:0] tgt, input logic on, input logic off);
        @(negedge clk);
        if (tgt === dut_addr && tgt !== OWN_ADDR)
        begin
            ident_on  = on;
            ident_off = off;
        end
        @(negedge clk) {ident_on, ident_off} = 2'h0;
    endtask
endmodule

// [dv/nas_status_bench.sv]
`timescale 1ns/1ps

module nas_status_bench
    import nas_pkg::*;
;
    // Short millisecond so the slow flash periods fit the run
    localparam int D = 4;
    logic       clk = 1'b0, rst = 1'b1, own_tx = 1'b0, lamp, lamp_d = 1'b0;
    logic       bus_activity, ident_on, ident_off;
    logic [3:0] sel_high = 4'h0, sel_low = 4'h0;
    logic [7:0] a;
    logic [7:0] tbl[4] = '{8'h01, 8'hfa, 8'hfb, 8'hff};
    nas_net_s   net;
    nas_cfg_s   cfg;
    int         bad_count = 0, total_checks = 0, seed = 75, cyc = 0, t_rise = 0, meas = 0;
    bit         have_rise = 0;
    int         exp_q[$];

    nas_status #(.MS_DIV(D)) DUT (.clk(clk), .rst(rst), .sel_high(sel_high), .sel_low(sel_low),
        .bus_activity(bus_activity), .own_tx(own_tx), .ident_on(ident_on), .ident_off(ident_off),
        .net(net), .cfg(cfg), .lamp(lamp));
    nas_bus_node node (.clk(clk), .dut_addr(net.node_addr), .bus_activity(bus_activity),
        .ident_on(ident_on), .ident_off(ident_off));

    // Free-running clock
    initial
    begin
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset(input logic [7:0] ad);
        @(negedge clk) rst = 1'b1;
        {sel_high, sel_low} = ad;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    task automatic tx();
        @(negedge clk) own_tx = 1'b1;
        @(negedge clk) own_tx = 1'b0;
    endtask

    // Note an expected lamp time in ms, then wait for the monitor
    task automatic measure(input int kind, input int exp_ms);
        int n;
        n = 0;
        exp_q.push_back(exp_ms);
        have_rise = 0;
        meas = kind;
        while (exp_q.size() != 0 && n < 65000)
        begin
            @(negedge clk);
            n++;
        end
        meas = 0;
        if (exp_q.size() != 0)
        begin
            bad_count++;
            $display("[ERR] t=%0t lamp timeout got=%h exp=%h", $time, 0, exp_ms);
            exp_q.delete();
        end
    endtask

    // Compare one lamp time against the oldest note, within two ticks
    task automatic chk(input int c);
        int e;
        e = exp_q.pop_front();
        cmp((c >= e * D - 2 * D && c <= e * D + 2 * D) ? e : c / D, e);
    endtask

    // Monitor: lamp period (rise to rise) or width (rise to fall), read where lamp has settled
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        if (lamp === 1'b1 && lamp_d !== 1'b1)
        begin
            if (meas == 1 && have_rise && exp_q.size() != 0)
                chk(cyc - t_rise);
            t_rise = cyc;
            have_rise = 1;
        end
        if (lamp === 1'b0 && lamp_d === 1'b1 && meas == 2 && exp_q.size() != 0)
            chk(cyc - t_rise);
        lamp_d = lamp;
    end

    // Watchdog
    initial
    begin
        repeat (15000 * D) @(posedge clk); // Worst case run is near 37k cycles
        bad_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        do_reset(8'h00);
        cmp(32'(net), 32'h0);
        cmp(32'(cfg), {27'h0, 1'b1, 1'b0, ROUTE_2IN_2OUT, 1'b1});
        node.frame();
        tx();
        node.ident(8'h00, 1'b1, 1'b0);
        measure(1, DETACH_PERIOD_MS);
        measure(2, FLASH_ON_MS);
        $display("detached test done");
        for (int i = 0; i < 7; i++)
        begin
            a = (i < 4) ? tbl[i] : 8'(($random(seed) & 255) % 250 + 1);
            do_reset(a);
            cmp({net.addr_valid, net.net_enable}, (a <= ADDR_MAX) ? 2'h3 : 2'h0);
            cmp(32'(cfg), {27'h0, 1'b0, 1'b1, ROUTE_2IN_2OUT, 1'b0});
            {sel_high, sel_low} = ~a;
            repeat (3) @(negedge clk);
            cmp(net.node_addr, a);
        end
        $display("address test done");
        measure(1, IDLE_PERIOD_MS);
        while (lamp !== 1'b0) @(negedge clk);
        tx();
        repeat (300) @(negedge clk);
        cmp(lamp, 1'b0);
        node.frame();
        repeat (3) @(negedge clk);
        cmp(net.bus_seen, 1'b1);
        cmp(lamp, 1'b0);
        tx();
        measure(2, TX_LAMP_MS);
        tx();
        repeat (50 * D) @(negedge clk);
        tx();
        measure(2, TX_LAMP_MS + 50);
        $display("transmit test done");
        node.ident(net.node_addr, 1'b1, 1'b1);
        measure(1, 2 * IDENT_HALF_MS);
        node.ident(net.node_addr, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        cmp(lamp, 1'b0);
        repeat (1500) @(negedge clk);
        cmp(lamp, 1'b0);
        $display("identify test done");
        end_sim();
    end
endmodule
